// ==== hbi_regs.svh ====
// Register offsets, field positions, reset values and timing counts of
// the converter host interface.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one register a word.
`ifndef HBI_REGS_SVH
`define HBI_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (low address byte)
// ----------------------------------------------------------------------
`define HBI_OFS_DATA_HI   8'h00
`define HBI_OFS_DATA_LO   8'h04
`define HBI_OFS_CTRL      8'h08
`define HBI_OFS_STATUS    8'h0C
`define HBI_OFS_INT_STAT  8'h10
`define HBI_OFS_INT_MASK  8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define HBI_ADDR_SEL_BIT  2
`define HBI_CTRL_WIDE     0
`define HBI_CTRL_CE       1
`define HBI_CTRL_RST      2'h2
`define HBI_ST_BUSY       0
`define HBI_ST_LEN8       1
`define HBI_ST_VALID      2
`define HBI_INT_DONE      0
`define HBI_INT_DROP      1
`define HBI_INT_RST       2'h0
`define HBI_LAST12        4'h0
`define HBI_LAST8         4'h4
`define HBI_FIRST_BIT     4'hB

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HBI_CLK_NS        4
`define HBI_CONV_TYP_NS   25000
`define HBI_CONV_MAX_NS   30000
`define HBI_CONV_CYC      ((`HBI_CONV_TYP_NS) / (`HBI_CLK_NS))
`define HBI_CONV_BITS     12

`endif

// ==== hbi_pkg.sv ====
// Types shared by the converter host interface modules.
// Assumes nothing beyond a SystemVerilog compiler.
package hbi_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef logic [11:0] hbi_code_t;

  typedef enum logic [1:0] {
    HBI_ST_IDLE = 2'b01,
    HBI_ST_CONV = 2'b10
  } hbi_state_e;

  // Weight of one result bit, used to build the trial value.
  function automatic hbi_code_t hbi_bit(input logic [3:0] idx);
    hbi_code_t w;
    w = 12'h001;
    hbi_bit = w << idx;
  endfunction

endpackage

// ==== hbi_tick.sv ====
// Step divider: one-cycle enable pulse every STEP_CYC clocks while run.
// Assumes run_i rises in the cycle after a conversion is launched.
`timescale 1ns/1ps
`default_nettype none
module hbi_tick #(
  parameter int STEP_CYC = 520
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      tick_o
);
  import hbi_pkg::*;

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    cnt_nxt  = 16'h0000;
    tick_nxt = 1'b0;
    if (run_i) begin
      if (cnt_r == 16'(STEP_CYC - 1)) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule
`default_nettype wire

// ==== hbi_sar.sv ====
// Successive approximation engine with its sample/hold.
// Assumes start_i is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none
`include "hbi_regs.svh"
module hbi_sar (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              start_i,
  input  wire logic              len8_i,
  input  wire logic              step_i,
  input  wire hbi_pkg::hbi_code_t analog_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   len8_o,
  output hbi_pkg::hbi_code_t     result_o
);
  import hbi_pkg::*;

  hbi_state_e state_r, state_nxt;
  hbi_code_t  hold_r, hold_nxt;
  hbi_code_t  res_r, res_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic       len8_r, len8_nxt;
  logic       busy_r, busy_nxt;
  logic       done_r, done_nxt;

  always_comb begin
    hbi_code_t trial;
    trial     = res_r | hbi_bit(idx_r);
    state_nxt = state_r;
    hold_nxt  = hold_r;
    res_nxt   = res_r;
    idx_nxt   = idx_r;
    len8_nxt  = len8_r;
    done_nxt  = 1'b0;
    case (state_r)
      HBI_ST_IDLE: begin
        hold_nxt = analog_i;
        if (start_i) begin
          state_nxt = HBI_ST_CONV;
          res_nxt   = 12'h000;
          idx_nxt   = `HBI_FIRST_BIT;
          len8_nxt  = len8_i;
        end
      end
      HBI_ST_CONV: begin
        if (step_i) begin
          if (trial <= hold_r) begin
            res_nxt = trial;
          end
          if (idx_r == (len8_r ? `HBI_LAST8 : `HBI_LAST12)) begin
            state_nxt = HBI_ST_IDLE;
            done_nxt  = 1'b1;
          end else begin
            idx_nxt = idx_r - 4'h1;
          end
        end
      end
      default: begin
        state_nxt = HBI_ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt == HBI_ST_CONV);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= HBI_ST_IDLE;
      hold_r  <= 12'h000;
      res_r   <= 12'h000;
      idx_r   <= 4'h0;
      len8_r  <= 1'b0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r  <= hold_nxt;
      res_r   <= res_nxt;
      idx_r   <= idx_nxt;
      len8_r  <= len8_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy_o   = busy_r;
  assign done_o   = done_r;
  assign len8_o   = len8_r;
  assign result_o = res_r;

endmodule
`default_nettype wire

// ==== hbi_adc_if.sv ====
// Host interface of a 12-bit converter with built-in sample/hold,
// reached by software as an AHB-Lite slave with zero wait states.
// Assumes a single master, word transfers, and haddr bits above 7
// already decoded into hsel_i.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "hbi_regs.svh"
module hbi_adc_if #(
  parameter int CONV_CYC = `HBI_CONV_CYC
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic [31:0]             hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  input  wire hbi_pkg::hbi_code_t analog_i,
  output logic                    busy_o,
  output logic                    irq_o
);
  import hbi_pkg::*;

  // --------------------------------------------------------------------
  // Step timing
  // --------------------------------------------------------------------
  // Twelve equal steps, rounded down so a full conversion never
  // exceeds the typical figure and stays well inside the maximum.
  localparam int STEP_CYC = CONV_CYC / `HBI_CONV_BITS;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic        valid_r, valid_nxt;
  logic        irq_r, irq_nxt;
  logic        ready_r, ready_nxt;
  logic        resp_r, resp_nxt;

  logic        take;
  logic        start_req;
  logic        start_go;
  logic        start_len8;
  logic        busy_eff;
  logic [1:0]  int_set;
  logic [1:0]  int_clr;

  logic        eng_busy;
  logic        eng_done;
  logic        eng_len8;
  hbi_code_t   eng_res;
  logic        step;

  // --------------------------------------------------------------------
  // Converter engine and its step divider
  // --------------------------------------------------------------------
  hbi_tick #(
    .STEP_CYC (STEP_CYC)
  ) u_tick (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (eng_busy),
    .tick_o  (step)
  );

  hbi_sar u_sar (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .start_i  (start_go),
    .len8_i   (start_len8),
    .step_i   (step),
    .analog_i (analog_i),
    .busy_o   (eng_busy),
    .done_o   (eng_done),
    .len8_o   (eng_len8),
    .result_o (eng_res)
  );

  // --------------------------------------------------------------------
  // Read data formatting
  // --------------------------------------------------------------------
  function automatic logic [31:0] data_word(input logic       lo_sel,
                                            input logic       wide,
                                            input hbi_code_t  res);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (wide) begin
      w[11:0] = res;
    end else if (!lo_sel) begin
      w[7:0] = res[11:4];
    end else begin
      w[7:0] = {res[3:0], 4'h0};
    end
    data_word = w;
  endfunction

  function automatic logic is_start(input logic [7:0] a);
    is_start = (a == `HBI_OFS_DATA_HI) || (a == `HBI_OFS_DATA_LO);
  endfunction

  function automatic logic [31:0] status_word(input logic busy,
                                              input logic len8,
                                              input logic valid);
    logic [31:0] w;
    w                = 32'h0000_0000;
    w[`HBI_ST_BUSY]  = busy;
    w[`HBI_ST_LEN8]  = len8;
    w[`HBI_ST_VALID] = valid;
    status_word = w;
  endfunction

  // --------------------------------------------------------------------
  // Start decode
  // --------------------------------------------------------------------
  // A start lands at the end of the write data phase. A read whose
  // address phase overlaps that data phase must already see busy,
  // otherwise a host reading straight after the start gets stale data.
  always_comb begin
    take       = hsel_i && htrans_i[1] && hready_i;
    start_req  = wr_pend_r && is_start(wr_addr_r);
    start_go   = start_req && !eng_busy;
    start_len8 = wr_addr_r[`HBI_ADDR_SEL_BIT];
    busy_eff   = eng_busy || start_go;
  end

  // --------------------------------------------------------------------
  // Address phase capture
  // --------------------------------------------------------------------
  // Only writes need the address kept: their effect lands one cycle
  // later, when the write data stand in the data phase.
  always_comb begin
    wr_pend_nxt = take && hwrite_i;
    wr_addr_nxt = take ? haddr_i[7:0] : wr_addr_r;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Read data and response
  // --------------------------------------------------------------------
  // The slave never stalls and never errors; the response still comes
  // from flops so that every bus output is registered.
  always_comb begin
    logic [7:0] ra;
    ra        = haddr_i[7:0];
    ready_nxt = 1'b1;
    resp_nxt  = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (take && !hwrite_i) begin
      case (ra)
        `HBI_OFS_DATA_HI,
        `HBI_OFS_DATA_LO: begin
          if (ctrl_r[`HBI_CTRL_CE] && !busy_eff) begin
            rdata_nxt = data_word(ra[`HBI_ADDR_SEL_BIT],
                                  ctrl_r[`HBI_CTRL_WIDE], eng_res);
          end
        end
        `HBI_OFS_CTRL: begin
          rdata_nxt[1:0] = ctrl_r;
        end
        `HBI_OFS_STATUS: begin
          rdata_nxt = status_word(busy_eff, eng_len8,
                                  valid_r && !start_go);
        end
        `HBI_OFS_INT_STAT: begin
          rdata_nxt[1:0] = stat_r;
        end
        `HBI_OFS_INT_MASK: begin
          rdata_nxt[1:0] = mask_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b1;
      resp_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      resp_r  <= resp_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    int_clr  = 2'h0;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `HBI_OFS_CTRL: begin
          ctrl_nxt = hwdata_i[1:0];
        end
        `HBI_OFS_INT_MASK: begin
          mask_nxt = hwdata_i[1:0];
        end
        `HBI_OFS_INT_STAT: begin
          int_clr = hwdata_i[1:0];
        end
        default: begin
          int_clr = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `HBI_CTRL_RST;
      mask_r <= `HBI_INT_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status and result valid
  // --------------------------------------------------------------------
  always_comb begin
    int_set                 = 2'h0;
    int_set[`HBI_INT_DONE]  = eng_done;
    int_set[`HBI_INT_DROP]  = start_req && eng_busy;
    // A new event wins over a clear written in the same cycle.
    stat_nxt  = (stat_r & ~int_clr) | int_set;
    valid_nxt = (valid_r && !start_go) || eng_done;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_r  <= `HBI_INT_RST;
      valid_r <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      valid_r <= valid_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt line
  // --------------------------------------------------------------------
  // Taken from the registered status, so the line lags a new event by
  // one cycle; in return it comes straight from a flop.
  always_comb begin
    irq_nxt = |(stat_r & mask_r);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign hrdata_o    = rdata_r;
  assign hreadyout_o = ready_r;
  assign hresp_o     = resp_r;
  assign busy_o      = eng_busy;
  assign irq_o       = irq_r;

endmodule
`default_nettype wire

// ==== hbi_adc_if_monitor.sv ====
// Checker for the converter host interface, bound to its top module.
// Assumes one clock, async active-low reset, zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module hbi_adc_if_monitor #(
  parameter int CONV_CYC = 6250
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic        busy_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int STEP    = CONV_CYC / 12;
  localparam int C12     = 12 * STEP + 1;
  localparam int C8      = 8 * STEP + 1;
  localparam int MAX_CYC = 7500;
  logic rdt, dat, wr_r, dat_r, a2_r, st_c, len8_r;
  int   bcnt;
  assign rdt  = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  assign dat  = haddr_i[7:3] == 5'h00;
  assign st_c = wr_r & dat_r;
  // Length is latched only from a start taken while idle.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {wr_r, dat_r, a2_r, len8_r} <= 4'h0;
      bcnt <= 0;
    end else begin
      wr_r <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      dat_r <= dat;
      a2_r <= haddr_i[2];
      bcnt <= busy_o ? bcnt + 1 : 0;
      if (st_c && !busy_o) len8_r <= a2_r;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_start_busy:
    assert property ($rose(busy_o) |-> $past(st_c))
    else $error("busy rose without a start write");
  chk_busy_len:
    assert property ($fell(busy_o) |-> bcnt == (len8_r ? C8 : C12))
    else $error("conversion length wrong");
  chk_conv_max:
    assert property (busy_o |-> bcnt < MAX_CYC)
    else $error("conversion too long");
  chk_busy_hold:
    assert property (busy_o && bcnt < C8 - 1 |=> busy_o)
    else $error("conversion cut short");
  chk_float_busy:
    assert property (rdt && dat && busy_o |=> hrdata_o == 32'h0)
    else $error("data driven while busy");
  chk_data_cause:
    assert property (hrdata_o != 32'h0 |-> $past(rdt))
    else $error("data driven outside a read");
  chk_upper_zero:
    assert property (rdt && dat |=> hrdata_o[31:12] == 20'h0)
    else $error("result wider than 12 bits");
  chk_bus_okay:
    assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  cover property ($fell(busy_o) && len8_r);
  cover property ($fell(busy_o) && !len8_r);
  cover property (wr_r && dat_r && busy_o);
endmodule

bind hbi_adc_if hbi_adc_if_monitor #(.CONV_CYC(CONV_CYC)) i_mon (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .busy_o(busy_o)
);
`default_nettype wire

// ==== hbi_host_model.sv ====
// Host model: a single AHB-Lite master doing word transfers.
// Assumes hready comes from the one slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none
module hbi_host_model #(
  parameter int GAP_CYC = 2500,
  parameter int MAX_CYC = 7500
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  input  wire logic        busy_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  logic [31:0] rd_q;
  initial begin
    {hsel_o, htrans_o, hwrite_o} = 4'h0;
    {haddr_o, hwdata_o} = 64'h0;
    hsize_o = 3'h2;
  end
  // Data is taken with the value that stood before the edge.
  always @(posedge mclk_i) rd_q <= hrdata_i;
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    while (rst_n_i !== 1'b1) @(posedge mclk_i);
    @(posedge mclk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'h2;
    haddr_o <= a;
    hwrite_o <= w;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= w ? d : ~hwdata_o;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    hwdata_o <= ~d;
    #1;
    q = rd_q;
  endtask
  // Stalls on busy, then leaves time for the hold stage to acquire.
  task automatic wait_idle();
    @(posedge mclk_i);
    while (busy_i !== 1'b0) @(posedge mclk_i);
    repeat (GAP_CYC) @(posedge mclk_i);
  endtask
  // Blind wait of the worst conversion time, busy not watched.
  task automatic wait_max();
    repeat (MAX_CYC) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ==== hbi_adc_if_bench.sv ====
// Bench for the converter host interface: register sequences.
// Assumes the host model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module hbi_adc_if_bench;
  import hbi_pkg::*;
  // ----------------------------------------------------------------
  // Set-up
  // ----------------------------------------------------------------
  logic        mclk, rst_n, hsel, hwrite, hready, hresp, busy, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  hbi_code_t   analog;
  int          num_errors = 0;
  int          cmp_count = 0;
  hbi_adc_if #(.CONV_CYC(48)) i_dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .analog_i(analog),
    .busy_o(busy), .irq_o(irq));
  hbi_host_model i_host (
    .mclk_i(mclk), .rst_n_i(rst_n), .hready_i(hready),
    .hrdata_i(hrdata), .busy_i(busy), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, {24'h0, a}, 32'h0, q);
    check(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, {24'h0, a}, d, q);
  endtask
  task automatic conv(input logic [7:0] a, input hbi_code_t v);
    @(posedge mclk) analog <= v;
    wr(a, 32'hDEAD_BEEF);
    i_host.wait_idle();
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Eight conversions and one blind wait need about 26000 cycles.
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    analog = 12'h000;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h08, 32'h2);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h18, 32'hFF);
    rd(8'h18, 32'h0);
    check({31'h0, busy}, 32'h0);
    $display("test reset values done");
    wr(8'h08, 32'h3);
    conv(8'h00, 12'hA5C);
    rd(8'h00, 32'hA5C);
    rd(8'h0C, 32'h4);
    conv(8'h04, 12'h3C7);
    rd(8'h00, 32'h3C0);
    rd(8'h0C, 32'h6);
    $display("test lengths done");
    wr(8'h08, 32'h2);
    conv(8'h00, 12'hA5C);
    rd(8'h00, 32'hA5);
    rd(8'h04, 32'hC0);
    conv(8'h04, 12'h3C7);
    rd(8'h04, 32'h0);
    rd(8'h00, 32'h3C);
    $display("test byte mode done");
    wr(8'h08, 32'h1);
    rd(8'h00, 32'h0);
    wr(8'h08, 32'h3);
    @(posedge mclk) analog <= 12'h800;
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    @(posedge mclk) analog <= 12'h111;
    wr(8'h04, 32'h0);
    i_host.wait_idle();
    rd(8'h00, 32'h800);
    rd(8'h10, 32'h3);
    rd(8'h0C, 32'h4);
    @(posedge mclk) analog <= 12'h7FF;
    wr(8'h00, 32'h0);
    check({31'h0, busy}, 32'h1);
    i_host.wait_max();
    check({31'h0, busy}, 32'h0);
    rd(8'h00, 32'h7FF);
    $display("test float and hold done");
    wr(8'h10, 32'h3);
    rd(8'h10, 32'h0);
    wr(8'h14, 32'h1);
    conv(8'h00, 12'h5A5);
    check({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h1);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    wr(8'h14, 32'h0);
    conv(8'h04, 12'h5A5);
    check({31'h0, irq}, 32'h0);
    rd(8'h10, 32'h1);
    $display("test interrupt done");
    complete_run();
  end
endmodule
`default_nettype wire
